//--- src/charger_otg_limit_adc_regs.svh
// register offsets, field positions, reset values and limit weights for the result bank
`ifndef CHARGER_OTG_LIMIT_ADC_REGS_SVH
`define CHARGER_OTG_LIMIT_ADC_REGS_SVH

`define OFS_LIMIT_LOW        8'h08
`define OFS_LIMIT_HIGH       8'h09
`define OFS_POWER_MON        8'h26
`define OFS_BUS_VOLTAGE      8'h27
`define OFS_DISCHARGE_CUR    8'h28
`define OFS_CHARGE_CUR       8'h29
`define OFS_COMPARATOR_IN    8'h2a
`define OFS_INPUT_CUR        8'h2b
`define OFS_BATTERY_VOLTAGE  8'h2c
`define OFS_SYSTEM_VOLTAGE   8'h2d
`define OFS_MAKER_ID         8'h2e
`define OFS_PART_ID          8'h2f

`define LIMIT_RESET          8'h00
`define LIMIT_RSVD_BIT       7
`define CURRENT_RSVD_BIT     7
`define LIMIT_LSB_MA         50
`define LIMIT_W6_MA          13'hc80
`define LIMIT_W5_MA          13'h640
`define LIMIT_W4_MA          13'h320
`define LIMIT_W3_MA          13'h190
`define LIMIT_W2_MA          13'h0c8
`define LIMIT_W1_MA          13'h064
`define LIMIT_W0_MA          13'h032
`define UNMAPPED_READ        8'h00

`endif

//--- src/charger_otg_limit_adc_pkg.sv
// types shared by the result bank
package charger_otg_limit_adc_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [12:0] milliamp_t;
	typedef logic [6:0]  limit_code_t;
endpackage : charger_otg_limit_adc_pkg

//--- src/charger_otg_limit_adc_regs.sv
// host register bank: reverse output current limit, converter results, identification
`timescale 1ns/1ps
`default_nettype none
`include "charger_otg_limit_adc_regs.svh"

module charger_otg_limit_adc_regs
	import charger_otg_limit_adc_pkg::*;
#(
	parameter byte_t MAKER_CODE = 8'h5a, // arbitrary value
	parameter byte_t PART_CODE  = 8'ha5  // arbitrary value
) (
	input  wire logic      clock_in,
	input  wire logic      srst_in,
	input  wire logic      reg_write_in,
	input  wire logic      reg_read_in,
	input  wire byte_t     reg_addr_in,
	input  wire byte_t     reg_wdata_in,
	output byte_t          reg_rdata_out,
	output logic           reg_invalid_write_out,
	input  wire byte_t     system_power_monitor_in,
	input  wire byte_t     input_bus_voltage_in,
	input  wire logic [6:0] discharge_current_in,
	input  wire logic [6:0] charge_current_in,
	input  wire byte_t     comparator_input_voltage_in,
	input  wire byte_t     input_current_in,
	input  wire byte_t     battery_voltage_in,
	input  wire byte_t     system_voltage_in,
	output limit_code_t    reverse_output_limit_code_out,
	output milliamp_t      reverse_output_limit_ma_out
);

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// the limit is the sum of the weights of the set code bits, 3200 mA at bit 6
	function automatic milliamp_t limit_to_ma(input limit_code_t code);
		milliamp_t sum;
		sum = '0;
		if (code[6]) begin
			sum = sum + `LIMIT_W6_MA;
		end
		if (code[5]) begin
			sum = sum + `LIMIT_W5_MA;
		end
		if (code[4]) begin
			sum = sum + `LIMIT_W4_MA;
		end
		if (code[3]) begin
			sum = sum + `LIMIT_W3_MA;
		end
		if (code[2]) begin
			sum = sum + `LIMIT_W2_MA;
		end
		if (code[1]) begin
			sum = sum + `LIMIT_W1_MA;
		end
		if (code[0]) begin
			sum = sum + `LIMIT_W0_MA;
		end
		limit_to_ma = sum;
	endfunction : limit_to_ma

	// the reserved top bit of a current result always reads zero
	function automatic byte_t current_byte(input logic [6:0] code);
		current_byte = {1'b0, code};
	endfunction : current_byte

	function automatic logic offset_is(input byte_t addr, input byte_t ofs);
		offset_is = (addr == ofs);
	endfunction : offset_is

	// and-or select slice: the byte shows only while its offset is hit
	function automatic byte_t gate_byte(input logic hit, input byte_t value);
		gate_byte = {8{hit}} & value;
	endfunction : gate_byte

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	byte_t       limit_high;
	byte_t       limit_low;
	logic        invalid_write;
	limit_code_t limit_code;
	milliamp_t   limit_ma;
	byte_t       rdata;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	wire logic at_limit_low;
	wire logic at_limit_high;
	wire logic at_power_mon;
	wire logic at_bus_voltage;
	wire logic at_discharge;
	wire logic at_charge;
	wire logic at_comparator;
	wire logic at_input_current;
	wire logic at_battery;
	wire logic at_system_voltage;
	wire logic at_maker_id;
	wire logic at_part_id;
	wire logic at_result;
	wire logic at_mapped;

	assign at_limit_low = offset_is(
		reg_addr_in,
		`OFS_LIMIT_LOW
	);
	assign at_limit_high = offset_is(
		reg_addr_in,
		`OFS_LIMIT_HIGH
	);
	assign at_power_mon = offset_is(
		reg_addr_in,
		`OFS_POWER_MON
	);
	assign at_bus_voltage = offset_is(
		reg_addr_in,
		`OFS_BUS_VOLTAGE
	);
	assign at_discharge = offset_is(
		reg_addr_in,
		`OFS_DISCHARGE_CUR
	);
	assign at_charge = offset_is(
		reg_addr_in,
		`OFS_CHARGE_CUR
	);
	assign at_comparator = offset_is(
		reg_addr_in,
		`OFS_COMPARATOR_IN
	);
	assign at_input_current = offset_is(
		reg_addr_in,
		`OFS_INPUT_CUR
	);
	assign at_battery = offset_is(
		reg_addr_in,
		`OFS_BATTERY_VOLTAGE
	);
	assign at_system_voltage = offset_is(
		reg_addr_in,
		`OFS_SYSTEM_VOLTAGE
	);
	assign at_maker_id = offset_is(
		reg_addr_in,
		`OFS_MAKER_ID
	);
	assign at_part_id = offset_is(
		reg_addr_in,
		`OFS_PART_ID
	);

	assign at_result = at_power_mon
		|| at_bus_voltage
		|| at_discharge
		|| at_charge
		|| at_comparator
		|| at_input_current
		|| at_battery
		|| at_system_voltage
		|| at_maker_id
		|| at_part_id;
	assign at_mapped = at_limit_low || at_limit_high || at_result;

	// ------------------------------------------------------------
	// write side
	// ------------------------------------------------------------
	// a one in reserved bit 7 is the host's fault: it is flagged and stored as written
	wire logic        write_limit_high;
	wire logic        write_limit_low;
	wire logic        write_reserved_one;
	wire byte_t       next_limit_high;
	wire byte_t       next_limit_low;
	wire logic        next_invalid_write;
	wire limit_code_t next_limit_code;
	wire milliamp_t   next_limit_ma;

	assign write_limit_high   = reg_write_in && at_limit_high;
	assign write_limit_low    = reg_write_in && at_limit_low;
	assign write_reserved_one = write_limit_high && reg_wdata_in[`LIMIT_RSVD_BIT];
	assign next_limit_high    = write_limit_high ? reg_wdata_in : limit_high;
	assign next_limit_low     = write_limit_low ? reg_wdata_in : limit_low;
	assign next_invalid_write = write_reserved_one;
	// outputs follow the value being stored, so they move with the register
	assign next_limit_code    = next_limit_high[6:0];
	assign next_limit_ma      = limit_to_ma(next_limit_code);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			limit_high <= `LIMIT_RESET;
		end else begin
			limit_high <= next_limit_high;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			limit_low <= `LIMIT_RESET;
		end else begin
			limit_low <= next_limit_low;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			invalid_write <= 1'b0;
		end else begin
			invalid_write <= next_invalid_write;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			limit_code <= 7'(`LIMIT_RESET);
		end else begin
			limit_code <= next_limit_code;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			limit_ma <= 13'(`LIMIT_RESET);
		end else begin
			limit_ma <= next_limit_ma;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			rdata <= `UNMAPPED_READ;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// read side
	// ------------------------------------------------------------
	// results are sampled on the read so the byte stays put while the host shifts it
	// writes to result and id offsets reach no storage at all
	wire byte_t read_limit_low;
	wire byte_t read_limit_high;
	wire byte_t read_power_mon;
	wire byte_t read_bus_voltage;
	wire byte_t read_discharge;
	wire byte_t read_charge;
	wire byte_t read_comparator;
	wire byte_t read_input_current;
	wire byte_t read_battery;
	wire byte_t read_system_voltage;
	wire byte_t read_maker_id;
	wire byte_t read_part_id;
	wire byte_t gated_limit_low;
	wire byte_t gated_limit_high;
	wire byte_t gated_power_mon;
	wire byte_t gated_bus_voltage;
	wire byte_t gated_discharge;
	wire byte_t gated_charge;
	wire byte_t gated_comparator;
	wire byte_t gated_input_current;
	wire byte_t gated_battery;
	wire byte_t gated_system_voltage;
	wire byte_t gated_maker_id;
	wire byte_t gated_part_id;
	wire byte_t mapped_byte;
	wire byte_t read_byte;
	wire byte_t next_rdata;

	assign read_limit_low      = limit_low;
	assign read_limit_high     = limit_high;
	assign read_power_mon      = system_power_monitor_in;
	assign read_bus_voltage    = input_bus_voltage_in;
	assign read_discharge      = current_byte(discharge_current_in);
	assign read_charge         = current_byte(charge_current_in);
	assign read_comparator     = comparator_input_voltage_in;
	assign read_input_current  = input_current_in;
	assign read_battery        = battery_voltage_in;
	assign read_system_voltage = system_voltage_in;
	assign read_maker_id       = MAKER_CODE;
	assign read_part_id        = PART_CODE;

	assign gated_limit_low = gate_byte(
		at_limit_low,
		read_limit_low
	);
	assign gated_limit_high = gate_byte(
		at_limit_high,
		read_limit_high
	);
	assign gated_power_mon = gate_byte(
		at_power_mon,
		read_power_mon
	);
	assign gated_bus_voltage = gate_byte(
		at_bus_voltage,
		read_bus_voltage
	);
	assign gated_discharge = gate_byte(
		at_discharge,
		read_discharge
	);
	assign gated_charge = gate_byte(
		at_charge,
		read_charge
	);
	assign gated_comparator = gate_byte(
		at_comparator,
		read_comparator
	);
	assign gated_input_current = gate_byte(
		at_input_current,
		read_input_current
	);
	assign gated_battery = gate_byte(
		at_battery,
		read_battery
	);
	assign gated_system_voltage = gate_byte(
		at_system_voltage,
		read_system_voltage
	);
	assign gated_maker_id = gate_byte(
		at_maker_id,
		read_maker_id
	);
	assign gated_part_id = gate_byte(
		at_part_id,
		read_part_id
	);

	assign mapped_byte = gated_limit_low
		| gated_limit_high
		| gated_power_mon
		| gated_bus_voltage
		| gated_discharge
		| gated_charge
		| gated_comparator
		| gated_input_current
		| gated_battery
		| gated_system_voltage
		| gated_maker_id
		| gated_part_id;
	assign read_byte  = at_mapped ? mapped_byte : `UNMAPPED_READ;
	assign next_rdata = reg_read_in ? read_byte : rdata;

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata_out                 = rdata;
	assign reg_invalid_write_out         = invalid_write;
	assign reverse_output_limit_code_out = limit_code;
	assign reverse_output_limit_ma_out   = limit_ma;

endmodule : charger_otg_limit_adc_regs
`default_nettype wire

//--- bench/result_source.sv
// stand-in converter presenting fixed result codes
`timescale 1ns/1ps
`default_nettype none
module result_source (output logic [7:0] pw, bv, cp, ic, bt, sv, output logic [6:0] dc, cc);
	assign {pw, bv, cp, ic, bt, sv} = 48'h11fe33ff4481;
	// current codes are 7 bits wide, so bit 7 of those bytes is never driven from here
	assign {dc, cc} = 14'h3fd5;
endmodule : result_source
`default_nettype wire

//--- bench/limit_bank_checker.sv
// port assertions for the limit and result bank
`timescale 1ns/1ps
`default_nettype none
module limit_bank_checker (input wire logic clock_in, srst_in, reg_write_in, reg_read_in,
	reg_invalid_write_out, input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
	input wire logic [6:0] reverse_output_limit_code_out, charge_current_in, discharge_current_in,
	input wire logic [12:0] reverse_output_limit_ma_out);
	default clocking @(posedge clock_in); endclocking
	default disable iff (srst_in);
	wire hw = reg_write_in && reg_addr_in == 8'h09;
	wire [6:0] lc = reverse_output_limit_code_out;
	property p_flag; hw && reg_wdata_in[7] |=> reg_invalid_write_out; endproperty
	a_flag: assert property (p_flag) else $error("flag missing");
	property p_noflag; !(hw && reg_wdata_in[7]) |=> !reg_invalid_write_out; endproperty
	a_noflag: assert property (p_noflag) else $error("stray flag");
	property p_code; hw |=> {1'b0, lc} == ($past(reg_wdata_in) & 8'h7f); endproperty
	a_code: assert property (p_code) else $error("code");
	property p_ma; reverse_output_limit_ma_out == 13'(lc * 50); endproperty
	a_ma: assert property (p_ma) else $error("ma");
	property p_hold; !hw |=> $stable(lc); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_rst; $past(srst_in) |-> lc == 7'h00 && reg_rdata_out == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("reset");
	property p_chg; reg_read_in && reg_addr_in == 8'h29 |=> reg_rdata_out[6:0] == $past(charge_current_in); endproperty
	a_chg: assert property (p_chg) else $error("charge");
	property p_dis; reg_read_in && reg_addr_in == 8'h28 |=> reg_rdata_out[6:0] == $past(discharge_current_in); endproperty
	a_dis: assert property (p_dis) else $error("discharge");
	c_flag: cover property (hw && reg_wdata_in[7]);
	c_low: cover property (reg_write_in && reg_addr_in == 8'h08);
	c_chg: cover property (reg_read_in && reg_addr_in == 8'h29);
endmodule : limit_bank_checker
bind charger_otg_limit_adc_regs limit_bank_checker chk_i (.*);
`default_nettype wire

//--- bench/charger_otg_limit_adc_regs_tb.sv
// self-checking bench for the limit and result bank
`timescale 1ns/1ps
`default_nettype none
module charger_otg_limit_adc_regs_tb;
	import charger_otg_limit_adc_pkg::*;
	logic clk = 0, rst = 1, we = 0, re = 0, fl;
	byte_t a = 8'h00, d = 8'h00;
	wire byte_t q, pw, bv, cp, ic, bt, sv;
	wire logic [6:0] dc, cc, code;
	wire logic iw;
	wire milliamp_t ma;
	int failures = 0, checks = 0, cyc = 0;
	byte_t res [10] = '{8'h11, 8'hfe, 8'h7f, 8'h55, 8'h33, 8'hff, 8'h44, 8'h81, 8'h5a, 8'ha5};
	byte_t wv [4] = '{8'h7f, 8'h40, 8'h01, 8'h85};
	result_source src (.pw(pw), .bv(bv), .cp(cp), .ic(ic), .bt(bt), .sv(sv), .dc(dc), .cc(cc));
	charger_otg_limit_adc_regs dut (.clock_in(clk), .srst_in(rst), .reg_write_in(we),
		.reg_read_in(re), .reg_addr_in(a), .reg_wdata_in(d), .reg_rdata_out(q),
		.reg_invalid_write_out(iw), .system_power_monitor_in(pw), .input_bus_voltage_in(bv),
		.discharge_current_in(dc), .charge_current_in(cc), .comparator_input_voltage_in(cp),
		.input_current_in(ic), .battery_voltage_in(bt), .system_voltage_in(sv),
		.reverse_output_limit_code_out(code), .reverse_output_limit_ma_out(ma));
	initial forever #5 clk = ~clk;
	always @(posedge clk) if (++cyc == 2000) begin failures++; tally_and_finish(); end
	task chk(input string n, input logic [15:0] e, s);
		checks++;
		if (s !== e) begin failures++; $display("[FAIL] %s exp %h got %h", n, e, s); end
	endtask : chk
	// strobe for one edge, catch the flag pulse, then let outputs settle
	task acc(input logic w, input byte_t ad, wd);
		@(negedge clk); we = w; re = !w; a = ad; d = wd;
		@(negedge clk); we = 0; re = 0; fl = iw;
		@(negedge clk);
	endtask : acc
	task tally_and_finish;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (8) @(negedge clk); rst = 0;
		acc(0, 8'h09, 0); chk("high", 0, q); chk("ma", 0, ma);
		acc(0, 8'h08, 0); chk("low", 0, q); $display("reset test done");
		foreach (wv[i]) begin
			acc(1, 8'h09, wv[i]); chk("ma", wv[i][6:0] * 50, ma); chk("flag", wv[i][7], fl);
		end
		acc(0, 8'h09, 0); chk("stored", 8'h85, q); $display("limit test done");
		acc(1, 8'h08, 8'ha5); chk("code", 7'h05, code); acc(0, 8'h08, 0); chk("low", 8'ha5, q);
		for (int i = 0; i < 10; i++) begin
			acc(1, 8'(8'h26 + i), ~res[i]); acc(0, 8'(8'h26 + i), 0); chk("result", res[i], q);
		end
		acc(0, 8'h30, 0); chk("unmapped", 0, q); $display("result test done");
		tally_and_finish();
	end
endmodule : charger_otg_limit_adc_regs_tb
`default_nettype wire
